// ---- shared/pbr_pkg.sv ----
// shared constants and types for the basic port control and status registers
package pbr_pkg;
  // register indices on the management interface
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STAT = 5'h01;
  // control register field positions
  localparam int CTRL_SOFT_RST = 15;
  localparam int CTRL_LOOP = 14;
  localparam int CTRL_RATE_LO = 13;
  localparam int CTRL_NEG_EN = 12;
  localparam int CTRL_STANDBY = 11;
  localparam int CTRL_DETACH = 10;
  localparam int CTRL_NEG_RESTART = 9;
  localparam int CTRL_DUPLEX = 8;
  localparam int CTRL_COL_TEST = 7;
  localparam int CTRL_RATE_HI = 6;
  localparam int CTRL_ONE_WAY = 5;
  // fixed field values
  localparam logic [1:0] RATE_100M = 2'h1;
  localparam logic FULL_DUPLEX = 1'h1;
  localparam logic [4:0] CTRL_RSVD_VAL = 5'h00;
  localparam logic [3:0] OPSEL_NORMAL = 4'h3;
  // status register word: capabilities 15..9 zero, 8..6 set, 5..0 read zero
  localparam logic [15:0] STAT_WORD = 16'h01c0;
  // management frame layout
  localparam logic [1:0] FRAME_START = 2'h1;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [3:0] HDR_LAST = 4'hd;
  localparam logic [3:0] DATA_LAST = 4'hf;
  // frame receiver states
  typedef enum logic [2:0] {ST_IDLE, ST_HDR, ST_TA, ST_DATA, ST_DONE} pbr_state_t;
  // all state of the register bank except the pin synchronisers
  typedef struct packed {
    pbr_state_t st;
    logic [3:0] cnt;
    logic [13:0] hdr;
    logic [15:0] sh;
    logic mdc_prev;
    logic loop;
    logic standby;
    logic detach;
    logic one_way;
    logic oe;
    logic dout;
    logic rst_pulse;
    logic conflict;
    logic normal_req;
  } pbr_regs_t;
  localparam pbr_regs_t REGS_RST = '{st: ST_IDLE, cnt: 4'h0, hdr: 14'h0000, sh: 16'h0000, mdc_prev: 1'h0,
                                     loop: 1'h0, standby: 1'h0, detach: 1'h0, one_way: 1'h0, oe: 1'h0,
                                     dout: 1'h0, rst_pulse: 1'h0, conflict: 1'h0, normal_req: 1'h0};
endpackage

// ---- hw/pbr_sync2.sv ----
// two flip-flop synchroniser for pin inputs
module pbr_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pbr_sync_t;
  pbr_sync_t r;
  pbr_sync_t next_r;

  if (W < 1) begin : g_bad_width
    $error("width must be at least one");
  end

  always_comb begin
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign q = r.s2;
endmodule // pbr_sync2

// ---- hw/pbr_regs.sv ----
// basic port control and status registers behind the serial management interface
module pbr_regs (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // management pins
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  // port address and surrounding state
  input wire logic [4:0] phy_addr,
  input wire logic [3:0] operating_state_select,
  input wire logic link_up,
  // port control
  output logic loopback_en,
  output logic standby_power_down,
  output logic mac_side_detach,
  output logic tx_forward_en,
  output logic port_reset,
  output logic conflicting_control_event,
  output logic normal_mode_req
);
  pbr_pkg::pbr_regs_t r;
  pbr_pkg::pbr_regs_t next_r;
  logic mdc_s;
  logic mdio_s;
  logic rise;
  logic [1:0] op;
  logic [4:0] reg_idx;
  logic hit;
  logic is_read;
  logic commit;
  logic [15:0] wword;
  logic [15:0] ctrl_word;
  logic [15:0] rd_word;
  logic [13:0] hdr_new;
  logic req_sb;
  logic req_dt;
  logic sb_ok;
  logic dt_ok;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  pbr_sync2 #(.W(2)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .d({mdc, mdio_in}),
    .q({mdc_s, mdio_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode and read data

  assign rise = mdc_s && !r.mdc_prev;
  assign op = r.hdr[11:10];
  assign reg_idx = r.hdr[4:0];
  assign hit = (r.hdr[9:5] == phy_addr);
  assign is_read = (op == pbr_pkg::OP_READ);
  assign wword = {r.sh[14:0], mdio_s};
  assign hdr_new = {r.hdr[12:0], mdio_s};
  assign commit = rise && (r.st == pbr_pkg::ST_DATA) && (r.cnt == pbr_pkg::DATA_LAST) && !is_read && hit
                  && (reg_idx == pbr_pkg::REG_CTRL);

  always_comb begin
    ctrl_word = 16'h0000;
    ctrl_word[pbr_pkg::CTRL_LOOP] = r.loop;
    ctrl_word[pbr_pkg::CTRL_RATE_HI] = pbr_pkg::RATE_100M[1];
    ctrl_word[pbr_pkg::CTRL_RATE_LO] = pbr_pkg::RATE_100M[0];
    ctrl_word[pbr_pkg::CTRL_STANDBY] = r.standby;
    ctrl_word[pbr_pkg::CTRL_DETACH] = r.detach;
    ctrl_word[pbr_pkg::CTRL_DUPLEX] = pbr_pkg::FULL_DUPLEX;
    ctrl_word[pbr_pkg::CTRL_ONE_WAY] = r.one_way;
    ctrl_word[4:0] = pbr_pkg::CTRL_RSVD_VAL;
  end

  always_comb begin
    case (hdr_new[4:0])
      pbr_pkg::REG_CTRL: rd_word = ctrl_word;
      pbr_pkg::REG_STAT: rd_word = pbr_pkg::STAT_WORD;
      default: rd_word = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // control write: standby and detach exclusion

  assign req_sb = wword[pbr_pkg::CTRL_STANDBY];
  assign req_dt = wword[pbr_pkg::CTRL_DETACH];
  assign sb_ok = req_sb && !r.detach;
  assign dt_ok = req_dt && !r.standby && !sb_ok;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_r = r;
    next_r.mdc_prev = mdc_s;
    next_r.rst_pulse = 1'h0;
    next_r.conflict = 1'h0;
    next_r.normal_req = 1'h0;
    if (rise) begin
      case (r.st)
        pbr_pkg::ST_IDLE: begin
          // preamble optional: any low bit starts a frame
          if (!mdio_s) begin
            next_r.st = pbr_pkg::ST_HDR;
            next_r.cnt = 4'h1;
            next_r.hdr = 14'h0000;
          end
        end
        pbr_pkg::ST_HDR: begin
          next_r.hdr = hdr_new;
          next_r.cnt = r.cnt + 4'h1;
          if (r.cnt == pbr_pkg::HDR_LAST) begin
            next_r.cnt = 4'h0;
            if (hdr_new[13:12] == pbr_pkg::FRAME_START
                && (hdr_new[11:10] == pbr_pkg::OP_READ || hdr_new[11:10] == pbr_pkg::OP_WRITE)) begin
              next_r.st = pbr_pkg::ST_TA;
              next_r.sh = rd_word;
            end else begin
              next_r.st = pbr_pkg::ST_IDLE;
            end
          end
        end
        pbr_pkg::ST_TA: begin
          if (r.cnt == 4'h0) begin
            next_r.cnt = 4'h1;
          end else begin
            next_r.st = pbr_pkg::ST_DATA;
            next_r.cnt = 4'h0;
            next_r.oe = is_read && hit;
            next_r.dout = 1'h0;
          end
        end
        pbr_pkg::ST_DATA: begin
          next_r.dout = r.sh[15];
          next_r.sh = wword;
          next_r.cnt = r.cnt + 4'h1;
          if (r.cnt == pbr_pkg::DATA_LAST) begin
            next_r.cnt = 4'h0;
            next_r.st = is_read ? pbr_pkg::ST_DONE : pbr_pkg::ST_IDLE;
          end
        end
        pbr_pkg::ST_DONE: begin
          next_r.oe = 1'h0;
          next_r.dout = 1'h0;
          next_r.st = pbr_pkg::ST_IDLE;
        end
        default: begin
          next_r.st = pbr_pkg::ST_IDLE;
          next_r.oe = 1'h0;
        end
      endcase
    end
    if (commit) begin
      if (wword[pbr_pkg::CTRL_SOFT_RST]) begin
        next_r.loop = 1'h0;
        next_r.standby = 1'h0;
        next_r.detach = 1'h0;
        next_r.one_way = 1'h0;
        next_r.rst_pulse = 1'h1;
      end else begin
        next_r.loop = wword[pbr_pkg::CTRL_LOOP];
        next_r.one_way = wword[pbr_pkg::CTRL_ONE_WAY];
        next_r.standby = sb_ok;
        next_r.detach = dt_ok;
        next_r.conflict = (req_sb && !sb_ok) || (req_dt && !dt_ok);
        next_r.normal_req = r.standby && !sb_ok && (operating_state_select == pbr_pkg::OPSEL_NORMAL);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      r <= pbr_pkg::REGS_RST;
    end else if (ce) begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign mdio_out = r.dout;
  assign mdio_oe = r.oe;
  assign loopback_en = r.loop;
  assign standby_power_down = r.standby;
  assign mac_side_detach = r.detach;
  assign tx_forward_en = r.one_way || link_up;
  assign port_reset = r.rst_pulse;
  assign conflicting_control_event = r.conflict;
  assign normal_mode_req = r.normal_req;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  chk_loop_write: assert property (ce && commit && !wword[15] |=> loopback_en == $past(wword[14]))
    else $error("loop bit not taken from write");
  chk_rate_fixed: assert property (ce && rise && r.st == pbr_pkg::ST_HDR && r.cnt == pbr_pkg::HDR_LAST
      && hdr_new[4:0] == pbr_pkg::REG_CTRL
      |=> r.st != pbr_pkg::ST_TA || r.sh[13] && !r.sh[6] && !r.sh[12] && !r.sh[9])
    else $error("control readback rate or negotiation bits wrong");
  chk_rsvd_zero: assert property (ce && rise && r.st == pbr_pkg::ST_HDR && r.cnt == pbr_pkg::HDR_LAST
      && hdr_new[4:0] == pbr_pkg::REG_CTRL
      |=> r.st != pbr_pkg::ST_TA || r.sh[4:0] == 5'h00 && r.sh[8] && !r.sh[7])
    else $error("control readback fixed bits wrong");
  chk_standby_set: assert property (ce && commit && !wword[15] && wword[11] && !r.detach |=> standby_power_down
      && !mac_side_detach)
    else $error("standby not entered");
  chk_detach_set: assert property (ce && commit && !wword[15] && wword[10] && !wword[11] && !r.standby
      |=> mac_side_detach && !standby_power_down)
    else $error("detach not entered");
  chk_conflict_sb: assert property (ce && commit && !wword[15] && wword[11] && r.detach
      |=> !standby_power_down && conflicting_control_event ##1 !conflicting_control_event || !ce)
    else $error("standby conflict not flagged");
  chk_conflict_dt: assert property (ce && commit && !wword[15] && wword[10] && r.standby
      |=> !mac_side_detach && conflicting_control_event)
    else $error("detach conflict not flagged");
  chk_normal_req: assert property (normal_mode_req |-> $past(standby_power_down) && !standby_power_down
      && $past(operating_state_select) == pbr_pkg::OPSEL_NORMAL)
    else $error("normal request without standby exit");
  chk_tx_forward: assert property (tx_forward_en == (r.one_way || link_up)
      && (!$rose(r.one_way) || $past(commit && wword[pbr_pkg::CTRL_ONE_WAY])))
    else $error("transmit forwarding wrong");
  chk_soft_reset: assert property (ce && commit && wword[15] |=> port_reset && !loopback_en
      && !standby_power_down && !mac_side_detach)
    else $error("soft reset did not restore defaults");
  chk_reset_clear: assert property (port_reset && ce |=> !port_reset)
    else $error("reset bit did not clear itself");
  chk_addr_drive: assert property ($rose(mdio_oe) |-> hit && is_read && !mdio_out)
    else $error("drove a frame for another address");
  chk_status_ro: assert property (ce && rise && r.st == pbr_pkg::ST_DATA && r.cnt == pbr_pkg::DATA_LAST
      && reg_idx == pbr_pkg::REG_STAT |=> $stable(r.loop) && $stable(r.standby) && $stable(r.detach))
    else $error("status write changed control");

  cov_read: cover property ($fell(mdio_oe));
  cov_write: cover property (ce && commit);
  cov_conflict: cover property (conflicting_control_event);
  cov_normal: cover property (normal_mode_req);
endmodule // pbr_regs

// ---- tb/pbr_sta_model.sv ----
// management controller model driving frames on the serial management pins
module pbr_sta_model (
  // clock
  input wire logic sys_clk,
  // pins from the port
  input wire logic mdio_out,
  input wire logic mdio_oe,
  // pins to the port
  output logic mdc,
  output logic mdio_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv = 1'b0;
  logic val = 1'b1;
  initial mdc = 1'b0;
  // resolved data line, pulled up when nobody drives it
  assign mdio_in = mdio_oe ? mdio_out : (drv ? val : 1'b1);
  //////////////////////////////////////////////////////////////////////////////
  task automatic half();
    repeat (6) @(negedge sys_clk);
  endtask
  task automatic pulse();
    half();
    mdc = 1'b1;
    half();
    mdc = 1'b0;
  endtask
  // one frame, clock stands still before and after
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] bits;
    logic is_rd;
    bits = {2'h1, op, pa, ra, 2'h2, wd};
    is_rd = (op == pbr_pkg::OP_READ);
    rd = 16'h0000;
    for (int i = 0; i < 32; i++) begin
      drv = !(is_rd && i >= 14);
      val = bits[31-i];
      pulse();
      if (is_rd && i >= 16) begin
        rd = {rd[14:0], mdio_in};
      end
    end
    drv = 1'b0;
    if (is_rd) begin
      pulse();
    end
    half();
  endtask
endmodule // pbr_sta_model

// ---- tb/tb_phy_basic_control_status_regs.sv ----
// testbench for the basic port control and status registers
module tb_phy_basic_control_status_regs;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] ADDR = 5'h05;
  localparam logic [4:0] RC = pbr_pkg::REG_CTRL;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] phy_addr = ADDR;
  logic [3:0] opsel = 4'h0;
  logic ce = 1'b1;
  logic link_up = 1'b0;
  logic mdc, mdio_in, mdio_out, mdio_oe, loop_en, stby, detach, tx_fwd, p_rst, conf, norm;
  int failures = 0;
  int checks_done = 0;
  int n_conf = 0;
  int n_norm = 0;
  int n_rst = 0;
  int n_oe = 0;
  logic [15:0] rd;
  always #12.5 sys_clk = ~sys_clk;
  always @(negedge sys_clk) begin
    n_conf += int'(conf === 1'b1);
    n_norm += int'(norm === 1'b1);
    n_rst += int'(p_rst === 1'b1);
    n_oe += int'(mdio_oe === 1'b1);
  end
  pbr_regs i_dut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_addr(phy_addr), .operating_state_select(opsel),
    .link_up(link_up), .loopback_en(loop_en), .standby_power_down(stby), .mac_side_detach(detach),
    .tx_forward_en(tx_fwd), .port_reset(p_rst), .conflicting_control_event(conf), .normal_mode_req(norm));
  pbr_sta_model i_sta (.sys_clk(sys_clk), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdc(mdc), .mdio_in(mdio_in));
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (failures == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] x;
    i_sta.frame(pbr_pkg::OP_WRITE, pa, ra, d, x);
  endtask
  task automatic rdr(input logic [4:0] pa, input logic [4:0] ra);
    i_sta.frame(pbr_pkg::OP_READ, pa, ra, 16'h0000, rd);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    check("loopback", 16'(loop_en), 16'h0000);
    check("tx_forward", 16'(tx_fwd), 16'h0000);
    rdr(ADDR, RC);
    check("ctrl", rd, 16'h2100);
    rdr(ADDR, pbr_pkg::REG_STAT);
    check("status", rd, 16'h01c0);
  endtask
  task automatic t_loop_oneway();
    wr(ADDR, RC, 16'h4020);
    check("loopback", 16'(loop_en), 16'h0001);
    check("tx_forward", 16'(tx_fwd), 16'h0001);
    rdr(ADDR, RC);
    check("ctrl", rd, 16'h6120);
    wr(ADDR, RC, 16'h0000);
    check("loopback", 16'(loop_en), 16'h0000);
    check("tx_forward", 16'(tx_fwd), 16'h0000);
    link_up = 1'b1;
    @(negedge sys_clk);
    check("tx_forward", 16'(tx_fwd), 16'h0001);
    link_up = 1'b0;
  endtask
  task automatic t_fixed();
    logic [15:0] v [3] = '{16'h1280, 16'h2340, 16'h0040};
    foreach (v[i]) begin
      wr(ADDR, RC, v[i]);
      rdr(ADDR, RC);
      check("ctrl", rd, 16'h2100);
    end
  endtask
  task automatic t_standby();
    int c;
    int m;
    c = n_conf;
    m = n_norm;
    opsel = 4'h3;
    wr(ADDR, RC, 16'h0800);
    check("standby", 16'(stby), 16'h0001);
    wr(ADDR, RC, 16'h0c00);
    check("detach", 16'(detach), 16'h0000);
    check("conflicts", 16'(n_conf - c), 16'h0001);
    wr(ADDR, RC, 16'h0000);
    check("standby", 16'(stby), 16'h0000);
    check("normal_reqs", 16'(n_norm - m), 16'h0001);
    @(negedge sys_clk) opsel = 4'h0;
    wr(ADDR, RC, 16'h0800);
    wr(ADDR, RC, 16'h0000);
    check("normal_reqs", 16'(n_norm - m), 16'h0001);
    wr(ADDR, RC, 16'h0400);
    check("detach", 16'(detach), 16'h0001);
    check("standby", 16'(stby), 16'h0000);
    wr(ADDR, RC, 16'h0c00);
    check("standby", 16'(stby), 16'h0000);
    check("conflicts", 16'(n_conf - c), 16'h0002);
    rdr(ADDR, RC);
    check("ctrl", rd, 16'h2500);
    wr(ADDR, RC, 16'h0000);
  endtask
  task automatic t_soft_reset();
    int r;
    r = n_rst;
    wr(ADDR, RC, 16'h4000);
    wr(ADDR, RC, 16'h8000);
    check("resets", 16'(n_rst - r), 16'h0001);
    check("loopback", 16'(loop_en), 16'h0000);
    rdr(ADDR, RC);
    check("ctrl", rd, 16'h2100);
  endtask
  task automatic t_bad_op();
    logic [1:0] ops [2] = '{2'h0, 2'h3};
    logic [15:0] x;
    foreach (ops[i]) begin
      i_sta.frame(ops[i], ADDR, RC, 16'h7fff, x);
      check("loopback", 16'(loop_en), 16'h0000);
      check("standby", 16'(stby), 16'h0000);
    end
    rdr(ADDR, RC);
    check("ctrl", rd, 16'h2100);
  endtask
  task automatic t_clock_enable();
    @(negedge sys_clk) ce = 1'b0;
    wr(ADDR, RC, 16'h4000);
    check("loopback", 16'(loop_en), 16'h0000);
    @(negedge sys_clk) ce = 1'b1;
    repeat (4) @(negedge sys_clk);
    wr(ADDR, RC, 16'h4000);
    check("loopback", 16'(loop_en), 16'h0001);
  endtask
  task automatic t_hard_reset();
    wr(ADDR, RC, 16'h4820);
    check("standby", 16'(stby), 16'h0001);
    @(negedge sys_clk) rst = 1'b1;
    @(negedge sys_clk);
    check("loopback", 16'(loop_en), 16'h0000);
    check("standby", 16'(stby), 16'h0000);
    check("tx_forward", 16'(tx_fwd), 16'h0000);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    rdr(ADDR, RC);
    check("ctrl", rd, 16'h2100);
  endtask
  task automatic t_address();
    int o;
    o = n_oe;
    wr(ADDR ^ 5'h01, RC, 16'h4000);
    check("loopback", 16'(loop_en), 16'h0000);
    rdr(ADDR ^ 5'h01, RC);
    check("foreign_read", rd, 16'hffff);
    check("drive_cycles", 16'(n_oe - o), 16'h0000);
    @(negedge sys_clk) phy_addr = 5'h1a;
    wr(5'h1a, RC, 16'h4000);
    check("loopback", 16'(loop_en), 16'h0001);
    wr(5'h1a, RC, 16'h0000);
    wr(5'h1a, pbr_pkg::REG_STAT, 16'hffff);
    rdr(5'h1a, pbr_pkg::REG_STAT);
    check("status", rd, 16'h01c0);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk) rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    t_defaults();
    t_loop_oneway();
    t_fixed();
    t_standby();
    t_soft_reset();
    t_bad_op();
    t_clock_enable();
    t_hard_reset();
    t_address();
    finish_test();
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    failures++;
    finish_test();
  end
endmodule // tb_phy_basic_control_status_regs
